// file: hw/pps_pkg.sv
// shared constants and types for the port pin state controller
package pps_pkg;

  localparam int unsigned PPS_ADDR_W  = 16;
  localparam int unsigned PPS_BYTE_W  = 8;
  localparam int unsigned PPS_P4_W    = 8;
  localparam int unsigned PPS_P5_W    = 3;
  localparam int unsigned PPS_P6_W    = 8;
  localparam int unsigned PPS_P8_W    = 6;

  localparam logic [1:0] PPS_MODE_EXP_NOROM = 2'h1;
  localparam logic [1:0] PPS_MODE_EXP_ROM   = 2'h2;
  localparam logic [1:0] PPS_MODE_SINGLE    = 2'h3;

  localparam logic [7:0] PPS_RD_RST = 8'h00;

  // what a pin bank does on the coming clock edge
  typedef enum logic [2:0] {
    PPS_FLOAT,
    PPS_LOW,
    PPS_HOLD,
    PPS_DRIVE,
    PPS_LOWDIR
  } pps_sel_e;

  typedef struct packed {
    logic [PPS_P4_W-1:0] p4;
    logic [PPS_P5_W-1:0] p5;
    logic [PPS_P6_W-1:0] p6;
    logic [PPS_P8_W-1:0] p8;
  } pps_gp_s;

endpackage

// file: hw/pps_pin_bank.sv
// one port's pin driver with remembered previous state
`timescale 1ns/1ps
`default_nettype none
module pps_pin_bank
  import pps_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire pps_sel_e     sel_in,
  input  wire logic [W-1:0] drv_val_in,
  input  wire logic [W-1:0] drv_en_in,
  input  wire logic         rst_low_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe_out
);

  if (W < 1) begin : g_bad_width
    $error("pps_pin_bank needs at least one pin");
  end

  logic [W-1:0] out_r;
  logic [W-1:0] out_nxt;
  logic [W-1:0] oe_r;
  logic [W-1:0] oe_nxt;
  logic [W-1:0] oe_cur;
  logic         fresh_r;
  logic         fresh_nxt;

  // reset level stays the previous state until the first edge after release,
  // so a hold right after reset keeps pins with rst_low_in set low instead of floating them
  assign oe_cur = (!rst_n_in || fresh_r) ? {W{rst_low_in}} : oe_r;

  always_comb begin
    out_nxt   = out_r;
    oe_nxt    = oe_cur;
    fresh_nxt = 1'b0;
    case (sel_in)
      PPS_FLOAT: begin
        oe_nxt = '0;
      end
      PPS_LOW: begin
        out_nxt = '0;
        oe_nxt  = '1;
      end
      PPS_DRIVE: begin
        out_nxt = drv_val_in;
        oe_nxt  = drv_en_in;
      end
      // drv_en selects the pins pulled low, the rest keep their state
      PPS_LOWDIR: begin
        out_nxt = out_r & ~drv_en_in;
        oe_nxt  = oe_cur | drv_en_in;
      end
      default: begin
        out_nxt = out_r;
        oe_nxt  = oe_cur;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_r   <= '0;
      oe_r    <= '0;
      fresh_r <= 1'b1;
    end else begin
      out_r   <= out_nxt;
      oe_r    <= oe_nxt;
      fresh_r <= fresh_nxt;
    end
  end

  assign pin_out    = out_r;
  assign pin_oe_out = oe_cur;

endmodule
`default_nettype wire

// file: hw/pps_port_ctrl.sv
// pin state control for the address, data, general and input-only ports
//
// What this block does
// [R1] mode 1 address ports: low, float, low, hold, drive
// [R2] mode 2 address: float reset, dir-low standby, hold sleep
// [R3] mode 2 normal: pin is address or input
// [R4] mode 3 address ports: float hw standby, hold sw standby/sleep, general I/O
// [R5] modes 1,2 data port floats except normal
// [R6] mode 3 data: float reset/hw, hold, I/O
// [R7] ports 4,5,6,8: float, hold, then I/O
// [R8] port 7 never drives, input only
`timescale 1ns/1ps
`default_nettype none
module pps_port_ctrl
  import pps_pkg::*;
(
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic [1:0]            mode_in,
  input  wire logic                  hw_stby_in,
  input  wire logic                  sw_stby_in,
  input  wire logic                  sleep_in,
  input  wire logic [PPS_ADDR_W-1:0] addr_in,
  input  wire logic [PPS_BYTE_W-1:0] dbus_wr_in,
  input  wire logic                  dbus_wr_en_in,
  input  wire logic [PPS_BYTE_W-1:0] lo_dr_in,
  input  wire logic [PPS_BYTE_W-1:0] lo_ddr_in,
  input  wire logic [PPS_BYTE_W-1:0] hi_dr_in,
  input  wire logic [PPS_BYTE_W-1:0] hi_ddr_in,
  input  wire logic [PPS_BYTE_W-1:0] dp_dr_in,
  input  wire logic [PPS_BYTE_W-1:0] dp_ddr_in,
  input  wire pps_gp_s               gp_dr_in,
  input  wire pps_gp_s               gp_ddr_in,
  input  wire logic [PPS_BYTE_W-1:0] input_only_port_pins_in,
  output logic      [PPS_BYTE_W-1:0] low_address_port_pins_out,
  output logic      [PPS_BYTE_W-1:0] low_address_port_pins_oe_out,
  output logic      [PPS_BYTE_W-1:0] high_address_port_pins_out,
  output logic      [PPS_BYTE_W-1:0] high_address_port_pins_oe_out,
  output logic      [PPS_BYTE_W-1:0] data_bus_port_pins_out,
  output logic      [PPS_BYTE_W-1:0] data_bus_port_pins_oe_out,
  output pps_gp_s                    gp_pin_out,
  output pps_gp_s                    gp_pin_oe_out,
  output logic      [PPS_BYTE_W-1:0] input_only_rd_out
);

  logic m1;
  logic m2;
  logic m3;
  assign m1 = (mode_in == PPS_MODE_EXP_NOROM);
  assign m2 = (mode_in == PPS_MODE_EXP_ROM);
  // unused mode code 0 is served as single-chip, the safest choice
  assign m3 = !m1 && !m2;

  pps_sel_e                  lo_sel;
  pps_sel_e                  hi_sel;
  pps_sel_e                  dp_sel;
  pps_sel_e                  gp_sel;
  logic     [PPS_BYTE_W-1:0] lo_val;
  logic     [PPS_BYTE_W-1:0] lo_en;
  logic     [PPS_BYTE_W-1:0] hi_val;
  logic     [PPS_BYTE_W-1:0] hi_en;
  logic     [PPS_BYTE_W-1:0] dp_val;
  logic     [PPS_BYTE_W-1:0] dp_en;

  // hardware standby outranks software standby, which outranks sleep
  always_comb begin
    lo_val = addr_in[PPS_BYTE_W-1:0];
    hi_val = addr_in[PPS_ADDR_W-1:PPS_BYTE_W];
    lo_en  = '1;
    hi_en  = '1;
    if (hw_stby_in) begin
      lo_sel = PPS_FLOAT; // [R1]
    end else if (sw_stby_in) begin
      if (m1) begin
        lo_sel = PPS_LOW; // [R1]
      end else if (m2) begin
        lo_sel = PPS_LOWDIR; // [R2]
        lo_en  = lo_ddr_in;
        hi_en  = hi_ddr_in;
      end else begin
        lo_sel = PPS_HOLD; // [R4]
      end
    end else if (sleep_in) begin
      lo_sel = PPS_HOLD; // [R1] [R2] [R4]
    end else begin
      lo_sel = PPS_DRIVE;
      if (m2) begin
        lo_en = lo_ddr_in; // [R3]
        hi_en = hi_ddr_in;
      end else if (m3) begin
        lo_val = lo_dr_in; // [R4]
        hi_val = hi_dr_in;
        lo_en  = lo_ddr_in;
        hi_en  = hi_ddr_in;
      end
    end
    hi_sel = lo_sel;
  end

  always_comb begin
    dp_val = dp_dr_in;
    dp_en  = dp_ddr_in;
    if (hw_stby_in) begin
      dp_sel = PPS_FLOAT; // [R5] [R6]
    end else if (sw_stby_in || sleep_in) begin
      dp_sel = m3 ? PPS_HOLD : PPS_FLOAT; // [R5] [R6]
    end else begin
      dp_sel = PPS_DRIVE;
      if (!m3) begin
        dp_val = dbus_wr_in; // [R5]
        dp_en  = {PPS_BYTE_W{dbus_wr_en_in}};
      end
    end
  end

  always_comb begin
    if (hw_stby_in) begin
      gp_sel = PPS_FLOAT; // [R7]
    end else if (sw_stby_in || sleep_in) begin
      gp_sel = PPS_HOLD; // [R7]
    end else begin
      gp_sel = PPS_DRIVE;
    end
  end

  // only mode 1 holds the address pins low through reset
  pps_pin_bank #(.W(PPS_BYTE_W)) u_lo (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .sel_in      (lo_sel),
    .drv_val_in  (lo_val),
    .drv_en_in   (lo_en),
    .rst_low_in  (m1),
    .pin_out     (low_address_port_pins_out),
    .pin_oe_out  (low_address_port_pins_oe_out)
  );

  pps_pin_bank #(.W(PPS_BYTE_W)) u_hi (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .sel_in      (hi_sel),
    .drv_val_in  (hi_val),
    .drv_en_in   (hi_en),
    .rst_low_in  (m1),
    .pin_out     (high_address_port_pins_out),
    .pin_oe_out  (high_address_port_pins_oe_out)
  );

  pps_pin_bank #(.W(PPS_BYTE_W)) u_dp (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .sel_in      (dp_sel),
    .drv_val_in  (dp_val),
    .drv_en_in   (dp_en),
    .rst_low_in  (1'b0),
    .pin_out     (data_bus_port_pins_out),
    .pin_oe_out  (data_bus_port_pins_oe_out)
  );

  pps_pin_bank #(.W($bits(pps_gp_s))) u_gp (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .sel_in      (gp_sel),
    .drv_val_in  (gp_dr_in),
    .drv_en_in   (gp_ddr_in), // [R7]
    .rst_low_in  (1'b0),
    .pin_out     (gp_pin_out),
    .pin_oe_out  (gp_pin_oe_out)
  );

  // port 7 has no driver at all, its pins are only sampled
  logic [PPS_BYTE_W-1:0] rd7_r;
  logic [PPS_BYTE_W-1:0] rd7_nxt;

  always_comb begin
    rd7_nxt = input_only_port_pins_in; // [R8]
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd7_r <= PPS_RD_RST;
    end else begin
      rd7_r <= rd7_nxt;
    end
  end

  assign input_only_rd_out = rd7_r;

  // checks on settled operating conditions
  logic norm;
  assign norm = !hw_stby_in && !sw_stby_in && !sleep_in;

  sequence s_hw_two;
    hw_stby_in ##1 hw_stby_in;
  endsequence

  sequence s_sw_two(logic m);
    (m && sw_stby_in && !hw_stby_in) ##1 (m && sw_stby_in && !hw_stby_in);
  endsequence

  sequence s_sleep_two(logic m);
    (m && sleep_in && !sw_stby_in && !hw_stby_in) ##1
      (m && sleep_in && !sw_stby_in && !hw_stby_in);
  endsequence

  property p_m1_swstby_low;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      s_sw_two(m1) |-> (low_address_port_pins_oe_out == 8'hFF)
        && (high_address_port_pins_out == 8'h00);
  endproperty
  a_m1_swstby_low: assert property (p_m1_swstby_low) // [R1]
    else $error("mode 1 address pins not low in software standby");

  property p_m1_normal_addr;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (m1 && norm) |=> ({high_address_port_pins_out, low_address_port_pins_out}
        == $past(addr_in)) && (low_address_port_pins_oe_out == 8'hFF);
  endproperty
  a_m1_normal_addr: assert property (p_m1_normal_addr) // [R1]
    else $error("mode 1 address pins not driving the address");

  property p_m2_swstby_dirlow;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      s_sw_two(m2) |-> ((low_address_port_pins_oe_out & $past(lo_ddr_in))
        == $past(lo_ddr_in)) && ((low_address_port_pins_out & $past(lo_ddr_in)) == 8'h00);
  endproperty
  a_m2_swstby_dirlow: assert property (p_m2_swstby_dirlow) // [R2]
    else $error("mode 2 output-direction pins not low in software standby");

  property p_m2_sleep_hold;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      s_sleep_two(m2) |-> $stable(high_address_port_pins_out)
        && $stable(high_address_port_pins_oe_out);
  endproperty
  a_m2_sleep_hold: assert property (p_m2_sleep_hold) // [R2]
    else $error("mode 2 address pins changed in sleep");

  property p_m2_normal_sel;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (m2 && norm) |=> (low_address_port_pins_oe_out == $past(lo_ddr_in))
        && (low_address_port_pins_out == $past(addr_in[7:0]));
  endproperty
  a_m2_normal_sel: assert property (p_m2_normal_sel) // [R3]
    else $error("mode 2 address pin direction does not follow its configuration");

  property p_m3_standby_hold;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      s_sw_two(m3) |-> $stable(low_address_port_pins_out)
        && $stable(data_bus_port_pins_oe_out);
  endproperty
  a_m3_standby_hold: assert property (p_m3_standby_hold) // [R4]
    else $error("mode 3 pins changed in software standby");

  property p_exp_data_float;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      ((m1 || m2) && !norm) |=> (data_bus_port_pins_oe_out == 8'h00);
  endproperty
  a_exp_data_float: assert property (p_exp_data_float) // [R5]
    else $error("data port driven outside normal operation");

  property p_m3_data_io;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (m3 && norm) |=> (data_bus_port_pins_oe_out == $past(dp_ddr_in))
        && (data_bus_port_pins_out == $past(dp_dr_in));
  endproperty
  a_m3_data_io: assert property (p_m3_data_io) // [R6]
    else $error("mode 3 data port not acting as general port");

  property p_gp_hw_float;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      s_hw_two |-> (gp_pin_oe_out == '0) && (low_address_port_pins_oe_out == 8'h00);
  endproperty
  a_gp_hw_float: assert property (p_gp_hw_float) // [R7]
    else $error("pins driven in hardware standby");

  property p_in7_sample;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      1'b1 |=> (input_only_rd_out == $past(input_only_port_pins_in));
  endproperty
  a_in7_sample: assert property (p_in7_sample) // [R8]
    else $error("input-only port read value wrong");

endmodule
`default_nettype wire

// file: testbench/pps_board_model.sv
// board model: an LFSR source for the input-only port pins
`timescale 1ns/1ps
`default_nettype none
module pps_board_model (
  input  wire logic       core_clk_in,
  input  wire logic [7:0] seed_in,
  output logic      [7:0] input_only_port_pins_out
);
  logic [7:0] lfsr_r = 8'h5A;

  // pins move just after the edge, like every other input, so sampling sees settled levels
  always @(posedge core_clk_in) begin
    lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]} ^ seed_in;
    #1 input_only_port_pins_out <= lfsr_r;
  end
endmodule
`default_nettype wire

// file: testbench/test_pps_port_ctrl.sv
// self-checking bench for the port pin state controller
`timescale 1ns/1ps
`default_nettype none
module test_pps_port_ctrl;
  import pps_pkg::*;
  logic        core_clk_in, rst_n_in, hw, sw, slp, wen;
  logic [1:0]  mode;
  logic [15:0] addr;
  logic [7:0]  wd, lodr, loddr, hidr, hiddr, dpdr, dpddr, p7, seed;
  logic [7:0]  lo, looe, hi, hioe, dp, dpoe, rd, e_lo, e_looe, e_hi, e_hioe, e_rd;
  logic [24:0] e_dp, e_dpoe, e_gp, e_gpoe;
  pps_gp_s     gdr, gddr, gpo, gpoe;
  int          failures, compares, cyc;

  pps_port_ctrl pps_port_ctrl_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .mode_in(mode), .hw_stby_in(hw), .sw_stby_in(sw), .sleep_in(slp), .addr_in(addr),
    .dbus_wr_in(wd), .dbus_wr_en_in(wen), .lo_dr_in(lodr), .lo_ddr_in(loddr),
    .hi_dr_in(hidr), .hi_ddr_in(hiddr), .dp_dr_in(dpdr), .dp_ddr_in(dpddr),
    .gp_dr_in(gdr), .gp_ddr_in(gddr), .input_only_port_pins_in(p7),
    .low_address_port_pins_out(lo), .low_address_port_pins_oe_out(looe),
    .high_address_port_pins_out(hi), .high_address_port_pins_oe_out(hioe),
    .data_bus_port_pins_out(dp), .data_bus_port_pins_oe_out(dpoe),
    .gp_pin_out(gpo), .gp_pin_oe_out(gpoe), .input_only_rd_out(rd));
  pps_board_model pps_board_model_inst (.core_clk_in(core_clk_in), .seed_in(seed),
    .input_only_port_pins_out(p7));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  function automatic logic [1:0] eff(input logic [1:0] m);
    return (m == 2'h0) ? PPS_MODE_SINGLE : m;
  endfunction

  task automatic addr_nxt(input logic [7:0] a, dr, ddr, inout logic [7:0] v, oe);
    if (hw) oe = 8'h00;
    else if (sw && eff(mode) == PPS_MODE_EXP_NOROM) begin
      v = 8'h00;
      oe = 8'hFF;
    end else if (sw && eff(mode) == PPS_MODE_EXP_ROM) begin
      v = v & ~ddr;
      oe = oe | ddr;
    end else if (!sw && !slp) begin
      v = (eff(mode) == PPS_MODE_SINGLE) ? dr : a;
      oe = (eff(mode) == PPS_MODE_EXP_NOROM) ? 8'hFF : ddr;
    end
  endtask

  task automatic gen_nxt(input logic hold_ok, input logic [24:0] dr, ddr,
                         inout logic [24:0] v, oe);
    if (hw || ((sw || slp) && !hold_ok)) oe = '0;
    else if (!sw && !slp) begin
      v = dr;
      oe = ddr;
    end
  endtask

  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc > 4000) begin
      failures++;
      results();
    end
  end

  // reset acts at once, so the expected pin state follows it without an edge
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {e_lo, e_hi, e_dp, e_gp, e_rd, e_dpoe, e_gpoe} = '0;
      e_looe = (mode == PPS_MODE_EXP_NOROM) ? 8'hFF : 8'h00;
      e_hioe = e_looe;
    end else begin
      addr_nxt(addr[7:0], lodr, loddr, e_lo, e_looe);
      addr_nxt(addr[15:8], hidr, hiddr, e_hi, e_hioe);
      if (eff(mode) == PPS_MODE_SINGLE) gen_nxt(1'b1, 25'(dpdr), 25'(dpddr), e_dp, e_dpoe);
      else gen_nxt(1'b0, 25'(wd), 25'({8{wen}}), e_dp, e_dpoe);
      gen_nxt(1'b1, gdr, gddr, e_gp, e_gpoe);
      e_rd = p7;
    end
  end

  task automatic chk(input string nm, input logic [49:0] exp, got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // values are only compared where the pin is expected to drive
  always @(negedge core_clk_in) begin
    if (cyc > 2) begin
      chk("low address", 50'({e_looe, e_lo & e_looe}), 50'({looe, lo & e_looe}));
      chk("high address", 50'({e_hioe, e_hi & e_hioe}), 50'({hioe, hi & e_hioe}));
      chk("data port", {17'h0, e_dpoe[7:0], 17'h0, e_dp[7:0] & e_dpoe[7:0]},
          {17'h0, dpoe, 17'h0, dp & e_dpoe[7:0]});
      chk("general ports", {e_gpoe, e_gp & e_gpoe}, {gpoe, gpo & e_gpoe});
      chk("input only", 50'(e_rd), 50'(rd));
    end
  end

  task automatic rnd(input int n);
    int r;
    repeat (n) begin
      @(posedge core_clk_in);
      #1;
      r = $urandom_range(0, 5);
      {hw, sw, slp} = (r < 3) ? 3'b000 : 3'b001 << (r - 3);
      {addr, wd, lodr, loddr, hidr, hiddr, dpdr, dpddr, wen} = 73'({$urandom, $urandom, $urandom});
      {gdr, gddr} = 50'({$urandom, $urandom});
      seed = 8'($urandom);
    end
  endtask

  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    {hw, sw, slp, wen, addr, wd, lodr, loddr, hidr, hiddr, dpdr, dpddr, seed} = '0;
    {gdr, gddr} = '0;
    mode = PPS_MODE_EXP_NOROM;
    rst_n_in = 1'b0;
    failures = 0;
    compares = 0;
    cyc = 0;
    void'($urandom(32'h1d2523f8));
    repeat (16) @(posedge core_clk_in);
    #1 rst_n_in = 1'b1;
    addr = 16'h1234;
    @(posedge core_clk_in);
    #1 slp = 1'b1;
    addr = 16'hFFFF;
    repeat (3) @(posedge core_clk_in);
    #1;
    chk("address in sleep", 50'h1234, 50'({hi, lo}));
    $display("test sleep hold done");
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk_in);
      #1 mode = 2'(m);
      rst_n_in = 1'b0;
      repeat (4) @(posedge core_clk_in);
      #1 rst_n_in = 1'b1;
      rnd(400);
      $display("test mode %0d done", m);
    end
    results();
  end
endmodule
`default_nettype wire
